// >>> shared/asc_pkg.sv
// Shared constants and types for the asynchronous SRAM port controller.
// Assumes a single 25 MHz core clock and a 32K x 8 asynchronous SRAM on the pins.
package asc_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 40;
	localparam int GRADES = 3;
	localparam int CNT_W = 4;
	// Speed grade index 0, 1, 2 stands for the 70, 85 and 100 ns parts.
	localparam int T_RC_NS [GRADES] = '{70, 85, 100};
	localparam int T_AA_NS [GRADES] = '{70, 85, 100};
	localparam int T_ACS_NS [GRADES] = '{70, 85, 100};
	localparam int T_OE_NS [GRADES] = '{40, 45, 50};
	localparam int T_OH_NS [GRADES] = '{5, 5, 10};
	localparam int T_WC_NS [GRADES] = '{70, 85, 100};
	localparam int T_CW_NS [GRADES] = '{65, 75, 80};
	localparam int T_AW_NS [GRADES] = '{65, 75, 80};
	localparam int T_WP_NS [GRADES] = '{60, 60, 70};
	localparam int T_DW_NS [GRADES] = '{40, 40, 40};
	localparam int T_WR_NS [GRADES] = '{0, 0, 0};
	localparam int T_OHZ_NS [GRADES] = '{35, 35, 45};
	localparam int T_CHZ_NS [GRADES] = '{35, 35, 45};

	// Least times round up to whole cycles, never below one cycle.
	function automatic int cyc_min(input int ns);
		return (ns <= CLK_PERIOD_NS) ? 1 : (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : cyc_min

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max2

	typedef enum logic [1:0]
	{
		ASC_IDLE = 2'h0,
		ASC_STROBE = 2'h1,
		ASC_HOLD = 2'h3,
		ASC_TURN = 2'h2
	} asc_state_e;

	typedef struct packed
	{
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asc_req_s;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} asc_pins_s;

	localparam asc_pins_s PINS_RESET = '{addr: 15'h0000, cs_n: 1'h1, oe_n: 1'h1, we_n: 1'h1,
		dq_out: 8'h00, dq_oe: 1'h0};
endpackage : asc_pkg

// >>> verilog/asc_timer.sv
// Phase timer: a loadable down counter that reports when it has reached zero.
// Assumes the loader only loads while the previous phase has finished.
module asc_timer
	import asc_pkg::*;
#(
	parameter int W = CNT_W
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	if (W < 1)
	begin : g_chk
		$error("asc_timer: width must be at least one bit");
	end

	always_comb
	begin
		cnt_next = cnt_reg;
		if (load)
		begin
			cnt_next = load_val;
		end
		else if (cnt_reg != '0)
		begin
			cnt_next = cnt_reg - W'(1);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cnt_reg <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
		end
	end

	assign done = (cnt_reg == '0);
endmodule : asc_timer

// >>> verilog/asc_ctrl.sv
// Host-side controller for a 32K x 8 asynchronous SRAM with a shared data bus.
// Assumes pins are registered here and dq_in is sampled as synchronous to core_clk.
// The pad combines dq_out and dq_oe into the real bidirectional wire.

module asc_ctrl
	import asc_pkg::*;
#(
	parameter int GRADE = 0
)
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic req_valid,
	output logic req_ready,
	input wire asc_req_s req,
	output logic resp_valid,
	output logic [DATA_W-1:0] resp_data,
	output asc_pins_s pins,
	input wire logic [DATA_W-1:0] dq_in
);
	if (GRADE < 0 || GRADE >= GRADES)
	begin : g_chk_grade
		$error("asc_ctrl: speed grade index out of range");
	end

	// Read strobe length covers address, select and enable access and the read cycle.
	localparam int N_ACC = cyc_min(max2(max2(T_AA_NS[GRADE], T_ACS_NS[GRADE]),
		max2(T_OE_NS[GRADE], T_RC_NS[GRADE])));
	localparam int N_WP = cyc_min(max2(max2(T_WP_NS[GRADE], T_CW_NS[GRADE]),
		max2(T_AW_NS[GRADE], T_DW_NS[GRADE])));
	localparam int N_WREC = max2(max2(1, cyc_min(T_WR_NS[GRADE])), cyc_min(T_WC_NS[GRADE]) - N_WP);
	localparam int N_TURN = max2(cyc_min(T_OHZ_NS[GRADE]), cyc_min(T_CHZ_NS[GRADE]));

	if (N_ACC > (1 << CNT_W) || N_WP > (1 << CNT_W) || N_WREC > (1 << CNT_W)
		|| N_TURN > (1 << CNT_W))
	begin : g_chk_cnt
		$error("asc_ctrl: phase counts do not fit the timer");
	end

	localparam logic [CNT_W-1:0] LD_ACC = CNT_W'(N_ACC - 1);
	localparam logic [CNT_W-1:0] LD_WP = CNT_W'(N_WP - 1);
	localparam logic [CNT_W-1:0] LD_WREC = CNT_W'(N_WREC - 1);
	localparam logic [CNT_W-1:0] LD_TURN = CNT_W'(N_TURN - 1);

	asc_state_e state_reg;
	asc_state_e state_next;
	asc_pins_s pins_reg;
	asc_pins_s pins_next;
	logic wr_reg;
	logic wr_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic tmr_done;

	asc_timer #(.W(CNT_W)) u_timer
	(
		.core_clk(core_clk),
		.srst(srst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	always_comb
	begin
		state_next = state_reg;
		pins_next = pins_reg;
		wr_next = wr_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'h0;
		tmr_load = 1'h0;
		tmr_val = '0;
		unique case (state_reg)
			ASC_IDLE:
			begin
				if (req_valid)
				begin
					pins_next.addr = req.addr;
					pins_next.cs_n = 1'h0;
					wr_next = req.write;
					tmr_load = 1'h1;
					state_next = ASC_STROBE;
					if (req.write)
					begin
						// Select and write fall together, so the part never drives here.
						pins_next.we_n = 1'h0;
						pins_next.dq_out = req.wdata;
						pins_next.dq_oe = 1'h1;
						tmr_val = LD_WP;
					end
					else
					begin
						pins_next.oe_n = 1'h0;
						tmr_val = LD_ACC;
					end
				end
			end
			ASC_STROBE:
			begin
				if (tmr_done)
				begin
					// Select, output enable and write strobes all rise together and end the write pulse or the read strobe.
					pins_next.cs_n = 1'h1;
					pins_next.oe_n = 1'h1;
					pins_next.we_n = 1'h1;
					tmr_load = 1'h1;
					if (wr_reg)
					begin
						tmr_val = LD_WREC;
						state_next = ASC_HOLD;
					end
					else
					begin
						rdata_next = dq_in;
						rvalid_next = 1'h1;
						tmr_val = LD_TURN;
						state_next = ASC_TURN;
					end
				end
			end
			ASC_HOLD:
			begin
				if (tmr_done)
				begin
					// Data and address stay past the strobe edge for a safe hold.
					pins_next.dq_oe = 1'h0;
					state_next = ASC_IDLE;
				end
			end
			ASC_TURN:
			begin
				// The part may still drive the bus until its release time passes.
				if (tmr_done)
				begin
					state_next = ASC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_reg <= ASC_IDLE;
			pins_reg <= PINS_RESET;
			wr_reg <= 1'h0;
			rdata_reg <= '0;
			rvalid_reg <= 1'h0;
		end
		else
		begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			wr_reg <= wr_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign req_ready = (state_reg == ASC_IDLE);
	assign resp_valid = rvalid_reg;
	assign resp_data = rdata_reg;
	assign pins = pins_reg;

	// Helper counter for the length of the current read strobe.
	logic [CNT_W:0] rd_len_reg;
	always_ff @(posedge core_clk)
	begin
		if (srst || pins_reg.oe_n)
		begin
			rd_len_reg <= '0;
		end
		else
		begin
			rd_len_reg <= rd_len_reg + (CNT_W+1)'(1);
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sequence s_wr_pulse;
		(!pins_reg.we_n && !pins_reg.cs_n && pins_reg.dq_oe)[*2];
	endsequence

	sequence s_wr_release;
		(pins_reg.we_n && pins_reg.cs_n && pins_reg.dq_oe && $stable(pins_reg.addr)
			&& $stable(pins_reg.dq_out));
	endsequence

	property p_no_contention;
		pins_reg.dq_oe |-> !(!pins_reg.cs_n && !pins_reg.oe_n && pins_reg.we_n);
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("data driven while the memory may drive");

	// One whole turn cycle plus the idle cycle separate the read strobe from driving.
	property p_turnaround;
		$rose(pins_reg.dq_oe) |-> $past(pins_reg.oe_n, 1) && $past(pins_reg.oe_n, 2);
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("data driven too soon after a read");

	property p_we_inside_cs;
		!pins_reg.we_n |-> !pins_reg.cs_n && pins_reg.oe_n;
	endproperty
	a_we_inside_cs: assert property (p_we_inside_cs)
		else $error("write strobe outside chip select or with output enable");

	// A reset during the first strobe cycle cuts the pulse on purpose, so it is not judged.
	property p_write_shape;
		$fell(pins_reg.we_n) && !srst |-> s_wr_pulse ##1 s_wr_release;
	endproperty
	a_write_shape: assert property (p_write_shape)
		else $error("write pulse too short or not released cleanly");

	property p_write_addr;
		(!pins_reg.we_n && $past(!pins_reg.we_n)) |-> $stable(pins_reg.addr)
			&& $stable(pins_reg.dq_out);
	endproperty
	a_write_addr: assert property (p_write_addr)
		else $error("address or data moved during the write pulse");

	property p_cs_fall_with_we;
		($fell(pins_reg.cs_n) && req_ready == 1'h0 && wr_reg) |-> $fell(pins_reg.we_n);
	endproperty
	a_cs_fall_with_we: assert property (p_cs_fall_with_we)
		else $error("select fell apart from the write strobe");

	property p_read_len;
		$rose(pins_reg.oe_n) |-> rd_len_reg >= (CNT_W+1)'(N_ACC);
	endproperty
	a_read_len: assert property (p_read_len)
		else $error("read strobe shorter than the access time");

	property p_read_addr;
		(!pins_reg.oe_n && $past(!pins_reg.oe_n)) |-> $stable(pins_reg.addr);
	endproperty
	a_read_addr: assert property (p_read_addr)
		else $error("address moved during a read");

	property p_resp;
		$rose(pins_reg.oe_n) |-> resp_valid ##1 !resp_valid;
	endproperty
	a_resp: assert property (p_resp)
		else $error("read answer not a single pulse at strobe end");

	property p_ready_idle;
		$fell(pins_reg.cs_n) |-> $past(req_ready) && !req_ready;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("cycle started without an accepted request");
endmodule : asc_ctrl

// >>> test/asc_sram_model.sv
// Behavioural model of the 32K x 8 asynchronous SRAM on the controller's pins.
// Assumes the bench resolves the shared data bus and feeds the level back as bus.
module asc_sram_model
	import asc_pkg::*;
(
	input wire asc_pins_s pins,
	input wire logic [DATA_W-1:0] bus,
	input wire logic [7:0] acc_ns,
	output logic [DATA_W-1:0] dq_dev,
	output logic dq_dev_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic reading;
	assign reading = !pins.cs_n && !pins.oe_n && pins.we_n;
	// The byte lands when the first strobe rises, so the bus is taken at the end of the overlap.
	always @(posedge (pins.cs_n | pins.we_n))
	begin
		mem[pins.addr] = bus;
	end
	// Old data stays until the access time has run, so a slow part still meets the hold time.
	always @(reading or pins.addr)
	begin
		#((reading === 1'b1) ? acc_ns : 5);
		dq_dev = mem[pins.addr];
		dq_dev_oe = reading;
	end
endmodule : asc_sram_model

// >>> test/asc_ctrl_tb.sv
// Self-checking bench for the SRAM port controller at the 70 ns grade.
// Assumes the SRAM model of asc_sram_model on the far side of the pins.
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module asc_ctrl_tb
	import asc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	logic req_ready;
	asc_req_s req = '0;
	logic resp_valid;
	logic [DATA_W-1:0] resp_data;
	asc_pins_s pins;
	logic [DATA_W-1:0] bus;
	logic [DATA_W-1:0] last = 8'h00;
	logic [DATA_W-1:0] dq_dev;
	logic dq_dev_oe;
	logic [7:0] acc_ns = 8'h0A;
	int n_fail = 0;
	int checked = 0;
	int lat;
	int wlow;

	asc_ctrl #(.GRADE(0)) u_asc_ctrl (.core_clk(core_clk), .srst(srst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp_data(resp_data),
		.pins(pins), .dq_in(bus));
	asc_sram_model u_asc_sram_model (.pins(pins), .bus(bus), .acc_ns(acc_ns), .dq_dev(dq_dev),
		.dq_dev_oe(dq_dev_oe));

	// A released bus shows the inverse of its last level, so stale data never reads as good.
	always @*
	begin
		bus = (pins.dq_oe === 1'b1) ? pins.dq_out : (dq_dev_oe === 1'b1) ? dq_dev : ~last;
	end
	always @(posedge core_clk) last <= bus;
	initial forever #20 core_clk = ~core_clk;

	always @(negedge core_clk)
	begin
		if (!srst && !pins.we_n)
		begin
			`CHK({pins.cs_n, pins.oe_n, pins.dq_oe}, 3'h3)
		end
		if (!srst && !pins.oe_n)
		begin
			`CHK(pins.dq_oe, 1'b0)
		end
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic do_req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{write: w, addr: a, wdata: d};
		@(negedge core_clk);
		while (!req_ready && n < 20)
		begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		req_valid <= 1'b0;
		lat = 0;
		wlow = 0;
		do
		begin
			@(negedge core_clk);
			lat++;
			wlow += !pins.we_n;
			if (!pins.cs_n) `CHK(pins.addr, a)
		end
		while (!(w ? req_ready : resp_valid) && lat < 20);
	endtask : do_req

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		do_req(1'b1, a, d);
		`CHK(lat, 4)
		`CHK(wlow, 2)
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		do_req(1'b0, a, 8'h00);
		`CHK(lat, 3)
		`CHK(resp_data, e)
	endtask : rd

	task automatic t_reset();
		`CHK(pins, PINS_RESET)
		`CHK({req_ready, resp_valid}, 2'h2)
	endtask : t_reset

	task automatic t_bounds();
		wr(15'h0000, 8'hA5);
		wr(15'h7FFF, 8'h5A);
		wr(15'h4000, 8'hFF);
		rd(15'h7FFF, 8'h5A);
		rd(15'h0000, 8'hA5);
		rd(15'h4000, 8'hFF);
	endtask : t_bounds

	// The slow partner uses the whole access time, so capture must wait for it.
	task automatic t_slow();
		acc_ns = 8'h46;
		wr(15'h1234, 8'h3C);
		rd(15'h1234, 8'h3C);
		rd(15'h0000, 8'hA5);
		acc_ns = 8'h0A;
	endtask : t_slow

	task automatic t_mid_reset();
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{write: 1'b1, addr: 15'h0100, wdata: 8'h77};
		@(posedge core_clk);
		req_valid <= 1'b0;
		srst <= 1'b1;
		@(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		`CHK(pins, PINS_RESET)
		`CHK(req_ready, 1'b1)
		rd(15'h7FFF, 8'h5A);
	endtask : t_mid_reset

	initial
	begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		t_reset();
		t_bounds();
		t_slow();
		t_mid_reset();
		close_out();
	end

	initial
	begin
		repeat (2000) @(posedge core_clk);
		n_fail++;
		close_out();
	end
endmodule : asc_ctrl_tb
